/* File: logic/dac_ctrl_pkg.sv */
// dac_ctrl_pkg: register map, field layout and reset values of the converter controller.
// assumes a 32-bit plain register port and a single master clock.
package dac_ctrl_pkg;
	localparam logic [7:0]  off_control_command  = 8'h00;
	localparam logic [7:0]  off_mode_config      = 8'h04;
	localparam logic [7:0]  off_sample_data      = 8'h08;
	localparam logic [7:0]  off_irq_enable_set   = 8'h0c;
	localparam logic [7:0]  off_irq_enable_clear = 8'h10;
	localparam logic [7:0]  off_irq_mask_view    = 8'h14;
	localparam logic [7:0]  off_irq_status_view  = 8'h18;
	localparam logic [7:0]  off_protect_mode     = 8'he4;
	localparam logic [7:0]  off_protect_status   = 8'he8;

	localparam int          soft_reset_pos       = 0;
	localparam int          ext_trig_en_pos      = 0;
	localparam int          trig_sel_lsb         = 1;
	localparam int          conv_en_pos          = 4;
	localparam int          word_pos             = 5;
	localparam int          startup_lsb          = 8;
	localparam int          divider_lsb          = 16;
	localparam int          protect_key_lsb      = 8;
	localparam int          fault_addr_lsb       = 8;
	localparam int          ready_pos            = 0;
	localparam int          empty_pos            = 2;

	localparam logic [23:0] protect_key_value    = 24'h44_4143;
	localparam logic [31:0] mode_reset           = 32'h0000_0000;
	localparam logic [31:0] mode_writable        = 32'hffff_ff3f;
	localparam logic [2:0]  irq_bits_mask        = 3'h7;
	localparam logic [2:0]  trig_sel_pin         = 3'h0;
	localparam int          fifo_depth           = 4;
	localparam int          sample_width         = 10;
	localparam int          second_lsb           = 16;
endpackage : dac_ctrl_pkg

/* File: logic/dac_sample_controller.sv */
// dac_sample_controller: register port, sample FIFO, trigger logic and converter feed.
// assumes a plain register master on mclk; trigger pins arrive asynchronously.
// Operation
// - internal mode converts when enabled, data queued and divider tick occurs
// - internal tick period equals divider value times master clock period
// - external mode holds each pending sample until selected source rises
// - external enable bit 0 free running, 1 external trigger mode
// - source select 0 pin, 1 to 3 timer channels, 4 to 7 reserved
// - waiting samples sit in a four half-word FIFO
// - samples not converted at once are queued; a write to a full FIFO is not blocked and overwrites an entry
// - ready flag high while a write can be accepted, low when full; here it is also held low while the converter is off
// - half-word mode takes one sample from bits 9 to 0
// - word mode takes bits 9 to 0 first, then 25 to 16
// - startup delay is startup field plus one clock periods
// - converter enable bit switches converter off at 0, on at 1
// - writing 1 to soft reset bit resets controller like hardware reset; here the pin synchronisers and edge flop keep their state
// - protected mode writes are cancelled, error flagged, address recorded
// - protect enable changes only with key matching, else whole write cancelled
// - all conversion timing derives from the master clock
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dac_sample_controller
	import dac_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output var  logic [31:0] rdata,
	// trigger sources
	input  wire logic        external_trigger_pin,
	input  wire logic [2:0]  timer_out,
	// converter side
	output var  logic [9:0]  analog_out_pin,
	output var  logic        sample_strobe,
	output var  logic        converter_enable,
	output var  logic        transmit_ready_flag
);
	typedef enum logic [1:0] {st_off = 2'b00, st_start = 2'b01, st_run = 2'b11} phase_e;

	// trigger source choice, reserved codes give no source
	function automatic logic pick_source(input logic [2:0] sel, input logic [3:0] src);
		logic r;
		r = 1'b0;
		if (sel < 3'h4)
			r = src[sel[1:0]];
		return r;
	endfunction : pick_source

	// write strobe aimed at one register offset
	function automatic logic write_to(input logic w, input logic [7:0] a, input logic [7:0] target);
		return w && a == target;
	endfunction : write_to

	// synchronisers
	logic [3:0]  sync1;
	logic [3:0]  sync2;
	logic [3:0]  sync3;
	logic [3:0]  stable;
	logic [3:0]  next_stable;
	logic        sel_prev;
	logic        next_sel_prev;

	// registers
	logic [31:0] mode;
	logic [31:0] next_mode;
	logic        protect_enable;
	logic        next_protect_enable;
	logic        protect_error_flag;
	logic        next_protect_error_flag;
	logic [7:0]  protect_fault_address;
	logic [7:0]  next_protect_fault_address;
	logic [2:0]  irq_mask;
	logic [2:0]  next_irq_mask;
	logic [31:0] next_rdata;

	// FIFO
	logic [9:0]  fifo_mem [fifo_depth];
	logic [9:0]  next_fifo_mem [fifo_depth];
	logic [1:0]  wr_ptr;
	logic [1:0]  next_wr_ptr;
	logic [1:0]  rd_ptr;
	logic [1:0]  next_rd_ptr;
	logic [2:0]  count;
	logic [2:0]  next_count;

	// timing
	phase_e      phase;
	phase_e      next_phase;
	logic [15:0] div_cnt;
	logic [15:0] next_div_cnt;
	logic [7:0]  start_cnt;
	logic [7:0]  next_start_cnt;
	logic [9:0]  next_analog;
	logic        next_strobe;
	logic        next_ready;

	logic        soft_reset;
	logic        sel_now;
	logic        trig_event;
	logic        tick;
	logic        pop;
	logic        data_wr;
	logic [2:0]  push_n;
	logic        mode_blocked;
	logic [3:0]  slots_after;

	assign soft_reset   = write_to(wr, addr, off_control_command) && wdata[soft_reset_pos];
	assign data_wr      = write_to(wr, addr, off_sample_data);
	assign mode_blocked = write_to(wr, addr, off_mode_config) && protect_enable;

	// pin inputs: three flops, change accepted when second and third agree
	// a one-cycle runt seen by only one of the two never reaches stable
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1    <= 4'h0;
			sync2    <= 4'h0;
			sync3    <= 4'h0;
			stable   <= 4'h0;
			sel_prev <= 1'b0;
		end
		else
		begin
			sync1    <= {timer_out, external_trigger_pin};
			sync2    <= sync1;
			sync3    <= sync2;
			stable   <= next_stable;
			sel_prev <= next_sel_prev;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_filter
			always_comb
			begin
				next_stable[g] = (sync2[g] == sync3[g]) ? sync3[g] : stable[g];
			end
		end
	endgenerate

	assign sel_now = pick_source(mode[trig_sel_lsb +: 3], stable);

	always_comb
	begin
		next_sel_prev = sel_now;
	end

	// rising edge on the chosen source
	assign trig_event = sel_now && !sel_prev;

	// internal tick every divider cycles; zero treated as one
	assign tick = (div_cnt == 16'h0000);

	// pick internal or external cause; bit low means free running
	// pop only once startup has elapsed
	// enable checked too: phase leaves run one edge after a disable
	assign pop = phase == st_run && mode[conv_en_pos] && count != 3'h0
		&& (mode[ext_trig_en_pos] ? trig_event : tick);

	// register and protection logic
	always_comb
	begin
		next_mode                  = mode;
		next_protect_enable        = protect_enable;
		next_protect_error_flag    = protect_error_flag;
		next_protect_fault_address = protect_fault_address;
		next_irq_mask              = irq_mask;
		next_rdata                 = 32'h0000_0000;
		// unmapped offsets ignore writes and read as zero
		if (wr)
		begin
			unique case (addr)
				off_mode_config:
				begin
					// protected mode write cancelled and recorded
					if (protect_enable)
					begin
						next_protect_error_flag    = 1'b1;
						next_protect_fault_address = addr;
					end
					else
						next_mode = wdata & mode_writable;
				end
				off_protect_mode:
				begin
					// key must match or the write is dropped
					if (wdata[protect_key_lsb +: 24] == protect_key_value)
						next_protect_enable = wdata[0];
				end
				off_irq_enable_set:
					next_irq_mask = irq_mask | (wdata[2:0] & irq_bits_mask);
				off_irq_enable_clear:
					next_irq_mask = irq_mask & ~wdata[2:0];
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
		if (rd)
		begin
			unique case (addr)
				off_mode_config:
					next_rdata = mode;
				off_irq_mask_view:
					next_rdata = {29'h0, irq_mask};
				off_irq_status_view:
					next_rdata = {29'h0, count == 3'h0, 1'b0, transmit_ready_flag};
				off_protect_mode:
					next_rdata = {31'h0, protect_enable};
				off_protect_status:
				begin
					next_rdata = {16'h0, protect_fault_address, 7'h0, protect_error_flag};
					// status clears on read; a new violation in the same cycle wins
					if (!mode_blocked)
					begin
						next_protect_error_flag    = 1'b0;
						next_protect_fault_address = 8'h00;
					end
				end
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// FIFO, four entries; writes queue; /packing
	always_comb
	begin
		for (int i = 0; i < fifo_depth; i++)
			next_fifo_mem[i] = fifo_mem[i];
		next_wr_ptr = wr_ptr;
		push_n      = 3'h0;
		if (data_wr)
		begin
			next_fifo_mem[wr_ptr] = wdata[sample_width - 1:0];
			next_wr_ptr           = wr_ptr + 2'h1;
			push_n                = 3'h1;
			if (mode[word_pos])
			begin
				next_fifo_mem[wr_ptr + 2'h1] = wdata[second_lsb +: sample_width];
				next_wr_ptr                  = wr_ptr + 2'h2;
				push_n                       = 3'h2;
			end
		end
		// count is a bit wider than the pointers so full and empty differ
		next_rd_ptr = pop ? rd_ptr + 2'h1 : rd_ptr;
		next_count  = count + push_n - {2'h0, pop};
		next_analog = pop ? fifo_mem[rd_ptr] : analog_out_pin;
		next_strobe = pop;
	end

	// startup (field+1) cycles, enable, mclk only
	always_comb
	begin
		next_phase     = phase;
		next_start_cnt = start_cnt;
		// free-running, so the tick phase does not depend on when data arrives
		if (div_cnt != 16'h0000)
			next_div_cnt = div_cnt - 16'h0001;
		else if (mode[divider_lsb +: 16] == 16'h0000)
			next_div_cnt = 16'h0000;
		else
			next_div_cnt = mode[divider_lsb +: 16] - 16'h0001;
		unique case (phase)
			st_off:
				if (mode[conv_en_pos])
				begin
					next_phase     = st_start;
					next_start_cnt = mode[startup_lsb +: 8];
				end
			st_start:
				if (!mode[conv_en_pos])
					next_phase = st_off;
				else if (start_cnt == 8'h00)
					next_phase = st_run;
				else
					next_start_cnt = start_cnt - 8'h01;
			st_run:
				if (!mode[conv_en_pos])
					next_phase = st_off;
			default:
				next_phase = st_off;
		endcase
		// ready while not full and enabled; word mode needs two slots
		// low until the converter is enabled
		slots_after = {1'b0, next_count} + (next_mode[word_pos] ? 4'h2 : 4'h1);
		// a word write needs two free entries or its second half would overwrite the oldest entry
		next_ready  = next_mode[conv_en_pos] && slots_after <= 4'(fifo_depth);
	end

	// soft reset acts as a hardware reset on the next edge
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode                  <= mode_reset;
			protect_enable        <= 1'b0;
			protect_error_flag    <= 1'b0;
			protect_fault_address <= 8'h00;
			irq_mask              <= 3'h0;
			rdata                 <= 32'h0000_0000;
			wr_ptr                <= 2'h0;
			rd_ptr                <= 2'h0;
			count                 <= 3'h0;
			phase                 <= st_off;
			div_cnt               <= 16'h0000;
			start_cnt             <= 8'h00;
			analog_out_pin        <= 10'h000;
			sample_strobe         <= 1'b0;
			converter_enable      <= 1'b0;
			transmit_ready_flag   <= 1'b0;
			for (int i = 0; i < fifo_depth; i++)
				fifo_mem[i] <= 10'h000;
		end
		else if (soft_reset)
		begin
			mode                  <= mode_reset;
			protect_enable        <= 1'b0;
			protect_error_flag    <= 1'b0;
			protect_fault_address <= 8'h00;
			irq_mask              <= 3'h0;
			rdata                 <= 32'h0000_0000;
			wr_ptr                <= 2'h0;
			rd_ptr                <= 2'h0;
			count                 <= 3'h0;
			phase                 <= st_off;
			div_cnt               <= 16'h0000;
			start_cnt             <= 8'h00;
			analog_out_pin        <= 10'h000;
			sample_strobe         <= 1'b0;
			converter_enable      <= 1'b0;
			transmit_ready_flag   <= 1'b0;
			for (int i = 0; i < fifo_depth; i++)
				fifo_mem[i] <= 10'h000;
		end
		else
		begin
			mode                  <= next_mode;
			protect_enable        <= next_protect_enable;
			protect_error_flag    <= next_protect_error_flag;
			protect_fault_address <= next_protect_fault_address;
			irq_mask              <= next_irq_mask;
			rdata                 <= next_rdata;
			wr_ptr                <= next_wr_ptr;
			rd_ptr                <= next_rd_ptr;
			count                 <= next_count;
			phase                 <= next_phase;
			div_cnt               <= next_div_cnt;
			start_cnt             <= next_start_cnt;
			analog_out_pin        <= next_analog;
			sample_strobe         <= next_strobe;
			converter_enable      <= next_mode[conv_en_pos];
			transmit_ready_flag   <= next_ready;
			for (int i = 0; i < fifo_depth; i++)
				fifo_mem[i] <= next_fifo_mem[i];
		end
	end
endmodule : dac_sample_controller
`default_nettype wire

/* File: verif/trig_source.sv */
// trig_source: timer channel and trigger pin model on the far side.
// assumes one fire pulse per trigger; lines idle low between pulses.
`timescale 1ns/1ps
`default_nettype none
module trig_source
#(
	parameter int HOLD = 3
)
(
	// clock
	input  wire logic       mclk,
	// request
	input  wire logic       fire,
	input  wire logic [1:0] sel,
	// trigger lines
	output var  logic       pin,
	output var  logic [2:0] tmr
);
	int         hold = 0;
	logic [1:0] cur  = 2'h0;
	// pulse held long enough for a three-flop synchroniser
	always @(posedge mclk)
	begin
		if (fire)
		begin
			hold <= HOLD;
			cur  <= sel;
		end
		else if (hold > 0)
			hold <= hold - 1;
	end
	always_comb
	begin
		pin = hold > 0 && cur == 2'h0;
		tmr = (hold > 0 && cur != 2'h0) ? 3'h1 << (cur - 2'h1) : 3'h0;
	end
endmodule : trig_source
`default_nettype wire

/* File: verif/dac_ctrl_chk.sv */
// dac_ctrl_chk: port-level properties of the converter controller.
// assumes mode and protect state can be mirrored from the register port.
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_chk
	import dac_ctrl_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// register port
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	// triggers
	input wire logic        external_trigger_pin,
	input wire logic [2:0]  timer_out,
	// converter side
	input wire logic [9:0]  analog_out_pin,
	input wire logic        sample_strobe,
	input wire logic        converter_enable,
	input wire logic        transmit_ready_flag
);
	logic       prot;
	logic       ext;
	logic [2:0] sel;
	logic       src_q;
	logic [3:0] since;
	logic       src;
	logic       swr;
	logic       mwr;
	assign swr = wr && addr == off_control_command && wdata[soft_reset_pos];
	assign mwr = wr && addr == off_mode_config;
	// reserved codes select nothing
	assign src = (sel > 3'h3) ? 1'b0 : (sel == 3'h0) ? external_trigger_pin : timer_out[sel[1:0] - 2'h1];
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prot  <= 1'b0;
			ext   <= 1'b0;
			sel   <= 3'h0;
			src_q <= 1'b0;
			since <= 4'hf;
		end
		else
		begin
			src_q <= src;
			// saturates so a stale edge never qualifies
			since <= (src && !src_q) ? 4'h0 : ((since == 4'hf) ? since : since + 4'h1);
			if (swr)
			begin
				prot <= 1'b0;
				ext  <= 1'b0;
				sel  <= 3'h0;
			end
			else if (mwr && !prot)
			begin
				ext <= wdata[ext_trig_en_pos];
				sel <= wdata[3:1];
			end
			else if (wr && addr == off_protect_mode && wdata[31:8] == protect_key_value)
				prot <= wdata[0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_rdata_idle; !rd |=> rdata == 32'h0000_0000; endproperty
	property p_en_write; mwr && !prot |=> converter_enable == $past(wdata[conv_en_pos]); endproperty
	property p_prot_block; mwr && prot |=> $stable(converter_enable); endproperty
	property p_off_noready; !converter_enable && !$past(converter_enable) |-> !transmit_ready_flag; endproperty
	property p_strobe_en; sample_strobe |-> $past(converter_enable); endproperty
	property p_soft_reset_bit; swr |=> !converter_enable && !transmit_ready_flag && analog_out_pin == 10'h000; endproperty
	property p_ext_edge; sample_strobe && ext |-> since < 4'ha; endproperty
	property p_analog_hold; !sample_strobe && !$past(swr) |-> $stable(analog_out_pin); endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_en_write: assert property (p_en_write) else $error("enable does not follow mode write");
	a_prot_block: assert property (p_prot_block) else $error("protected mode write took effect");
	a_off_noready: assert property (p_off_noready) else $error("ready while converter off");
	a_strobe_en: assert property (p_strobe_en) else $error("sample popped while off");
	a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset left outputs set");
	a_ext_edge: assert property (p_ext_edge) else $error("external pop without source edge");
	a_analog_hold: assert property (p_analog_hold) else $error("converter value changed without pop");
	c_ext_pop: cover property (sample_strobe && ext);
	c_prot_drop: cover property (mwr && prot);
	c_soft_reset_bit: cover property (swr);
endmodule : dac_ctrl_chk
bind dac_sample_controller dac_ctrl_chk chk_u (
	.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.external_trigger_pin(external_trigger_pin), .timer_out(timer_out), .analog_out_pin(analog_out_pin),
	.sample_strobe(sample_strobe), .converter_enable(converter_enable), .transmit_ready_flag(transmit_ready_flag)
);
`default_nettype wire

/* File: verif/dac_sample_controller_tb.sv */
// dac_sample_controller_tb: register-level tests of the converter controller.
// assumes the trigger source model on the trigger inputs and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module dac_sample_controller_tb
	import dac_ctrl_pkg::*;
;
	logic        mclk  = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic        fire  = 1'b0;
	logic [1:0]  fsel  = 2'h0;
	logic [31:0] rdata;
	logic        trig_pin;
	logic [2:0]  tmr;
	logic [9:0]  aout;
	logic        strobe;
	logic        en;
	logic        ready;
	logic [9:0]  exp_q[$];
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          last = 0;
	int          gap = 0;
	int          n;
	int          t0 = 0;

	initial forever #12.5 mclk = ~mclk;

	dac_sample_controller dut_u (
		.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.external_trigger_pin(trig_pin), .timer_out(tmr), .analog_out_pin(aout),
		.sample_strobe(strobe), .converter_enable(en), .transmit_ready_flag(ready)
	);
	trig_source src_u (.mclk(mclk), .fire(fire), .sel(fsel), .pin(trig_pin), .tmr(tmr));

	task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp32

	task automatic finish_test;
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		@(posedge mclk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		cmp32($sformatf("reg %h", a), exp, rdata & mask);
	endtask : rd_chk

	task automatic wr_smp(input logic [31:0] d, input bit two);
		exp_q.push_back(d[9:0]);
		if (two)
			exp_q.push_back(d[25:16]);
		wr_reg(off_sample_data, d);
	endtask : wr_smp

	task automatic wait_q(input int k);
		n = 0;
		while (exp_q.size() > k && n < 300)
		begin
			@(posedge mclk);
			n++;
		end
		cmp32("queue", k, exp_q.size());
	endtask : wait_q

	task automatic fire_src(input logic [1:0] s);
		@(posedge mclk);
		fire <= 1'b1;
		fsel <= s;
		@(posedge mclk);
		fire <= 1'b0;
	endtask : fire_src

	// every pop checked in order against what was written
	always @(negedge mclk)
		if (strobe === 1'b1)
		begin
			if (exp_q.size() == 0)
				cmp32("spare pop", 0, 1);
			else
				cmp32("sample", {22'h0, exp_q.pop_front()}, {22'h0, aout});
			gap  = cycles - last;
			last = cycles;
		end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			error_cnt++;
			finish_test();
		end
	end

	initial
	begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk(off_mode_config, 32'h0000_0000, 32'hffff_ffff);
		rd_chk(off_irq_status_view, 32'h0000_0000, 32'h0000_0001);
		rd_chk(8'hec, 32'h0000_0000, 32'hffff_ffff);
		// divider 4 keeps the tick at 10 MHz, under the converter limit
		wr_reg(off_mode_config, 32'h0004_0210);
		// outputs settle after the write edge
		#1;
		cmp32("enable", 1, {31'h0, en});
		cmp32("ready", 1, {31'h0, ready});
		wr_smp(32'h0155_0123, 1'b0);
		wr_smp(32'h0000_03ff, 1'b0);
		wr_smp(32'h0000_0200, 1'b0);
		wait_q(0);
		cmp32("period", 4, gap);
		wr_reg(off_mode_config, 32'h0004_0011);
		for (int i = 0; i < 4; i++)
			wr_smp(32'h0000_0040 + i, 1'b0);
		rd_chk(off_irq_status_view, 32'h0000_0000, 32'h0000_0001);
		for (int s = 0; s < 4; s++)
		begin
			wr_reg(off_mode_config, 32'h0004_0011 | (32'(s) << 1));
			fire_src(2'(s));
			wait_q(3 - s);
			if (s == 0)
				rd_chk(off_irq_status_view, 32'h0000_0001, 32'h0000_0001);
		end
		// reserved source code: a pin pulse must not convert
		wr_reg(off_mode_config, 32'h0004_0019);
		wr_smp(32'h0000_0155, 1'b0);
		fire_src(2'h0);
		repeat (12) @(posedge mclk);
		cmp32("reserved source", 1, exp_q.size());
		wr_reg(off_mode_config, 32'h0004_0011);
		fire_src(2'h0);
		wait_q(0);
		wr_reg(off_mode_config, 32'h0004_0030);
		wr_smp(32'h0234_0111, 1'b1);
		wait_q(0);
		wr_reg(off_protect_mode, 32'h1234_5601);
		rd_chk(off_protect_mode, 32'h0000_0000, 32'h0000_0001);
		wr_reg(off_protect_mode, 32'h4441_4301);
		rd_chk(off_protect_mode, 32'h0000_0001, 32'h0000_0001);
		wr_reg(off_mode_config, 32'h0000_0000);
		rd_chk(off_mode_config, 32'h0004_0030, 32'hffff_ffff);
		rd_chk(off_protect_status, 32'h0000_0401, 32'hffff_ffff);
		rd_chk(off_protect_status, 32'h0000_0000, 32'hffff_ffff);
		wr_reg(off_protect_mode, 32'h4441_4300);
		wr_reg(off_control_command, 32'h0000_0000);
		rd_chk(off_mode_config, 32'h0004_0030, 32'hffff_ffff);
		wr_reg(off_irq_enable_set, 32'h0000_0007);
		wr_reg(off_irq_enable_clear, 32'h0000_0002);
		rd_chk(off_irq_mask_view, 32'h0000_0005, 32'hffff_ffff);
		wr_reg(off_control_command, 32'h0000_0001);
		rd_chk(off_mode_config, 32'h0000_0000, 32'hffff_ffff);
		cmp32("enable", 0, {31'h0, en});
		rd_chk(off_irq_mask_view, 32'h0000_0000, 32'hffff_ffff);
		cmp32("ready", 0, {31'h0, ready});
		// startup 6 with divider 4 puts the first allowed pop on a tick
		wr_reg(off_mode_config, 32'h0004_0610);
		#1;
		t0 = cycles;
		wr_smp(32'h0000_02aa, 1'b0);
		wait_q(0);
		// one edge to leave off, startup+1 counting, then the pop edge
		cmp32("startup", 32'h0000_0009, last - t0);
		finish_test();
	end
endmodule : dac_sample_controller_tb
`default_nettype wire
